// >>> rtl/dsei_ctrl.sv
// Purpose: drive state, ramp/coast stop sequencing and emergency input
// Assumes: commands and pins synchronous to clk, speeds signed rpm
// Notes:   parameters reached by index/sub-index request, answer next cycle
`timescale 1ns/1ns
module dsei_ctrl
    import dsei_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter logic        EMG_EDGE = 1'b1
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           resetn,
    // parameter access
    input  wire dsei_req_type   req,
    output dsei_rsp_type        rsp,
    input  wire logic           write_lock,
    // drive control
    input  wire dsei_cmd_type   cmd,
    input  wire logic           alarm,
    input  wire logic           emg_pin,
    input  wire logic [15:0]    target_speed,
    input  wire logic [15:0]    actual_speed,
    input  wire logic [15:0]    brake_timeout,
    // drive outputs
    output dsei_state_type      drv_state,
    output logic [15:0]         speed_setpoint,
    output logic                torque_en,
    output logic                power_en,
    output logic                ramp_status,
    output logic                gp_input
);
    logic           rst_meta_r;
    logic           rst_n_r;
    logic           tick;
    logic [15:0]    opt_r, hold_r, step_r, tmo_r, sel_r, pol_r;
    logic           emg_status_r, emg_prev_r;
    logic           emg_rise, emg_trip, emg_ok, leave_run;
    dsei_state_type state_nxt;
    dsei_phase_type phase_r, phase_nxt;
    logic [15:0]    timer_r, timer_nxt, tmr_inc;
    logic [15:0]    sp_mag, act_mag, ramped, sp_nxt;
    logic [31:0]    ab_nxt;
    logic [15:0]    rd_nxt;
    logic           wr_ok;

    // reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // one 10 ms base for hold, ramp and brake timers
    dsei_tick #(
        .CYCLES (TICK_CYC)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n_r),
        .tick  (tick)
    );

    // emergency level after polarity, and its rising edge
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            emg_status_r <= 1'b0;
            emg_prev_r   <= 1'b0;
            gp_input     <= 1'b0;
        end else begin
            emg_status_r <= emg_pin ^ pol_r[0];
            emg_prev_r   <= emg_status_r;
            gp_input     <= ~sel_r[0] & emg_pin;
        end
    end

    // edge mode is a build-time choice, software cannot reach it
    assign emg_rise = emg_status_r & ~emg_prev_r;
    assign emg_trip = sel_r[0] & (EMG_EDGE ? emg_rise : emg_status_r);
    assign emg_ok   = ~sel_r[0] | ~emg_status_r;

    // drive state transitions
    always_comb begin
        state_nxt = drv_state;
        leave_run = 1'b0;
        case (drv_state)
            ST_SWON: begin
                if (cmd == CMD_ENABLE && emg_ok) begin
                    state_nxt = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (emg_trip || alarm || (cmd == CMD_DISABLE && emg_ok)) begin
                    state_nxt = ST_SWON;
                    leave_run = 1'b1;
                end else if (cmd == CMD_QSTOP) begin
                    state_nxt = ST_QSA;
                end
            end
            ST_QSA: begin
                if (emg_trip || cmd == CMD_DISABLE) begin
                    state_nxt = ST_SWON;
                end else if (cmd == CMD_ENABLE) begin
                    state_nxt = ST_OPEN;
                end
            end
            default: state_nxt = ST_SWON;
        endcase
    end

    // magnitudes; one tick is 10 ms so step in rpm*100/s is rpm per tick
    assign sp_mag  = speed_setpoint[15] ? 16'h0000 - speed_setpoint : speed_setpoint;
    assign act_mag = actual_speed[15] ? 16'h0000 - actual_speed : actual_speed;
    assign ramped  = (sp_mag <= step_r) ? 16'h0000 :
                     speed_setpoint[15] ? speed_setpoint + step_r
                                        : speed_setpoint - step_r;
    assign tmr_inc = timer_r + 16'h0001;

    // stop phase sequencing, parameters read live each tick
    always_comb begin
        phase_nxt = phase_r;
        timer_nxt = timer_r;
        sp_nxt    = speed_setpoint;
        case (phase_r)
            PH_IDLE: begin
                if (leave_run) begin
                    phase_nxt = opt_r[0] ? PH_RAMP : PH_COAST;
                    timer_nxt = 16'h0000;
                end
            end
            PH_RAMP: begin
                if (tick) begin
                    timer_nxt = tmr_inc;
                    sp_nxt    = ramped;
                    if (tmr_inc >= tmo_r) begin
                        phase_nxt = PH_IDLE;
                    end else if (ramped == 16'h0000) begin
                        phase_nxt = PH_HOLD;
                        timer_nxt = 16'h0000;
                    end
                end
            end
            PH_HOLD: begin
                if (tick) begin
                    timer_nxt = tmr_inc;
                    if (tmr_inc >= hold_r) begin
                        phase_nxt = PH_IDLE;
                    end
                end
            end
            PH_COAST: begin
                if (act_mag < STOP_RPM) begin
                    phase_nxt = PH_IDLE;
                end else if (tick) begin
                    timer_nxt = tmr_inc;
                    if (tmr_inc >= brake_timeout) begin
                        phase_nxt = PH_IDLE;
                    end
                end
            end
            default: phase_nxt = PH_IDLE;
        endcase
        // a new enable abandons any stop still running
        if (state_nxt == ST_OPEN) begin
            phase_nxt = PH_IDLE;
            sp_nxt    = target_speed;
        end else if (phase_nxt != PH_RAMP) begin
            sp_nxt = 16'h0000;
        end
    end

    // state, phase and outputs all from next values
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            drv_state      <= ST_SWON;
            phase_r        <= PH_IDLE;
            timer_r        <= 16'h0000;
            speed_setpoint <= 16'h0000;
            torque_en      <= 1'b0;
            power_en       <= 1'b0;
            ramp_status    <= 1'b0;
        end else begin
            drv_state      <= state_nxt;
            phase_r        <= phase_nxt;
            timer_r        <= timer_nxt;
            speed_setpoint <= sp_nxt;
            // quick-stop holds power but no torque
            torque_en      <= (state_nxt == ST_OPEN) || (phase_nxt != PH_IDLE);
            power_en       <= (state_nxt != ST_SWON) || (phase_nxt != PH_IDLE);
            ramp_status    <= (phase_nxt == PH_RAMP) || (phase_nxt == PH_HOLD);
        end
    end

    // request decode: sub-index, read-only, lock, range, cross checks
    always_comb begin
        ab_nxt = AB_NONE;
        rd_nxt = 16'h0000;
        wr_ok  = 1'b0;
        if (req.index == OBJ_STOP) begin
            if (req.sub > SUB_STP_LAST) begin
                ab_nxt = AB_NO_SUB;
            end else if (req.sub == SUB_COUNT) begin
                rd_nxt = ENTRY_COUNT;
                if (req.write) ab_nxt = AB_READ_ONLY;
            end else if (req.sub == SUB_STATUS) begin
                rd_nxt = {15'h0000, ramp_status};
                if (req.write) ab_nxt = AB_READ_ONLY;
            end else if (req.sub == SUB_OPTION) begin
                rd_nxt = opt_r;
                if (req.write && write_lock) ab_nxt = AB_LOCKED;
                else if (req.write && req.data > 16'h0001) ab_nxt = AB_RANGE;
                else wr_ok = req.write;
            end else if (req.sub == SUB_HOLD) begin
                rd_nxt = hold_r;
                if (req.write && write_lock) ab_nxt = AB_LOCKED;
                else if (req.write && (req.data == 16'h0000 || req.data[15]))
                    ab_nxt = AB_RANGE;
                else wr_ok = req.write;
            end else if (req.sub == SUB_STEP) begin
                rd_nxt = step_r;
                if (req.write && write_lock) ab_nxt = AB_LOCKED;
                else if (req.write && (req.data == 16'h0000 || req.data > MAX_STEP))
                    ab_nxt = AB_RANGE;
                else if (req.write && req.data >= tmo_r) ab_nxt = AB_TOO_HIGH;
                else wr_ok = req.write;
            end else begin
                rd_nxt = tmo_r;
                if (req.write && write_lock) ab_nxt = AB_LOCKED;
                else if (req.write && (req.data == 16'h0000 || req.data[15]))
                    ab_nxt = AB_RANGE;
                else if (req.write && req.data <= step_r) ab_nxt = AB_TOO_LOW;
                else wr_ok = req.write;
            end
        end else if (req.index == OBJ_EMG) begin
            if (req.sub > SUB_EMG_LAST) begin
                ab_nxt = AB_NO_SUB;
            end else if (req.sub == SUB_COUNT || req.sub == SUB_STATUS) begin
                rd_nxt = (req.sub == SUB_COUNT) ? ENTRY_COUNT
                                                : {15'h0000, emg_status_r};
                if (req.write) ab_nxt = AB_READ_ONLY;
            end else begin
                rd_nxt = (req.sub == SUB_OPTION) ? sel_r : pol_r;
                if (req.write && write_lock) ab_nxt = AB_LOCKED;
                else if (req.write && req.data > 16'h0001) ab_nxt = AB_RANGE;
                else wr_ok = req.write;
            end
        end else begin
            ab_nxt = AB_NO_OBJ;
        end
    end

    // answer one cycle after the request
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rsp <= '0;
        end else begin
            rsp.ack   <= req.valid;
            rsp.abort <= req.valid ? ab_nxt : AB_NONE;
            rsp.data  <= (req.valid && !req.write) ? rd_nxt : 16'h0000;
        end
    end

    // parameter storage, taken at once even while running
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            opt_r  <= RST_OPTION;
            hold_r <= RST_HOLD;
            step_r <= RST_STEP;
            tmo_r  <= RST_TMO;
            sel_r  <= RST_EMG_SEL;
            pol_r  <= RST_EMG_POL;
        end else if (req.valid && wr_ok) begin
            if (req.index == OBJ_STOP) begin
                if (req.sub == SUB_OPTION) opt_r <= req.data;
                else if (req.sub == SUB_HOLD) hold_r <= req.data;
                else if (req.sub == SUB_STEP) step_r <= req.data;
                else tmo_r <= req.data;
            end else begin
                if (req.sub == SUB_OPTION) sel_r <= req.data;
                else pol_r <= req.data;
            end
        end
    end

    // checks
    wire wr_stp = req.valid && req.write && req.index == OBJ_STOP && !write_lock;

    AST_RAMP_FROM_RUN: assert property (@(posedge clk) disable iff (!rst_n_r)
        phase_r == PH_IDLE && phase_nxt == PH_RAMP |-> drv_state == ST_OPEN && opt_r[0])
        else $error("ramp stop started outside run exit");
    AST_COAST_END: assert property (@(posedge clk) disable iff (!rst_n_r)
        phase_r == PH_COAST && act_mag < 16'h0005 && state_nxt != ST_OPEN
        |=> phase_r == PH_IDLE && !torque_en)
        else $error("coast did not end below 5 rpm");
    AST_TOO_HIGH: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_stp && req.sub == SUB_STEP && req.data != 16'h0000 && req.data <= MAX_STEP
        && req.data >= tmo_r |=> rsp.ack && rsp.abort == 32'h0609_0031)
        else $error("step write not refused as too high");
    AST_TOO_LOW: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_stp && req.sub == SUB_TMO && !req.data[15] && req.data != 16'h0000
        && req.data <= step_r |=> rsp.abort == 32'h0609_0032 && $stable(tmo_r))
        else $error("timeout write not refused as too low");
    AST_READ_ONLY: assert property (@(posedge clk) disable iff (!rst_n_r)
        req.valid && req.write && req.index == OBJ_EMG && req.sub == SUB_STATUS
        |=> rsp.abort == 32'h0601_0002)
        else $error("read-only write not refused");
    AST_NO_SUB: assert property (@(posedge clk) disable iff (!rst_n_r)
        req.valid && req.index == OBJ_STOP && req.sub > 8'h05 |=> rsp.abort == 32'h0609_0011)
        else $error("missing sub-index not refused");
    AST_LOCKED: assert property (@(posedge clk) disable iff (!rst_n_r)
        req.valid && req.write && write_lock && req.index == OBJ_STOP && req.sub == SUB_HOLD
        |=> rsp.abort == 32'h0800_0002 && $stable(hold_r))
        else $error("locked write not refused");
    AST_EMG_STATUS: assert property (@(posedge clk) disable iff (!rst_n_r)
        rst_n_r |=> emg_status_r == ($past(emg_pin) ^ $past(pol_r[0])))
        else $error("emergency status wrong polarity");
    AST_ENABLE_GATE: assert property (@(posedge clk) disable iff (!rst_n_r)
        drv_state == ST_SWON && sel_r[0] && emg_status_r |=> drv_state != ST_OPEN)
        else $error("run entered with emergency active");
    AST_QSTOP: assert property (@(posedge clk) disable iff (!rst_n_r)
        drv_state == ST_OPEN && cmd == CMD_QSTOP && !alarm && !emg_trip
        |=> drv_state == ST_QSA && !torque_en && power_en)
        else $error("quick-stop not entered with zero torque");
    AST_QSA_OFF: assert property (@(posedge clk) disable iff (!rst_n_r)
        drv_state == ST_QSA && cmd == CMD_DISABLE |=> drv_state == ST_SWON && !power_en)
        else $error("quick-stop disable left power on");
    AST_EMG_EXIT: assert property (@(posedge clk) disable iff (!rst_n_r)
        drv_state == ST_OPEN && sel_r[0] && $rose(emg_status_r)
        |=> drv_state == ST_SWON ##0 ramp_status == opt_r[0])
        else $error("emergency did not leave run");

    COV_RAMP_HOLD: cover property (@(posedge clk) disable iff (!rst_n_r)
        phase_r == PH_RAMP ##1 phase_r == PH_HOLD);
    COV_COAST: cover property (@(posedge clk) disable iff (!rst_n_r)
        phase_r == PH_COAST ##1 phase_r == PH_IDLE);
    COV_QSA_RUN: cover property (@(posedge clk) disable iff (!rst_n_r)
        drv_state == ST_QSA ##1 drv_state == ST_OPEN);

endmodule : dsei_ctrl

// >>> rtl/dsei_pkg.sv
// Purpose: shared constants and types of the stop and emergency input block
// Assumes: 10 MHz clock, parameter access by object index and sub-index
// Notes:   timers count 10 ms ticks, speeds are signed rpm
package dsei_pkg;

    // parameter objects and sub-indices
    localparam logic [15:0] OBJ_STOP     = 16'h3007;
    localparam logic [15:0] OBJ_EMG      = 16'h3008;
    localparam logic [7:0]  SUB_COUNT    = 8'h00;
    localparam logic [7:0]  SUB_OPTION   = 8'h01;
    localparam logic [7:0]  SUB_HOLD     = 8'h02;
    localparam logic [7:0]  SUB_STATUS   = 8'h03;
    localparam logic [7:0]  SUB_STEP     = 8'h04;
    localparam logic [7:0]  SUB_TMO      = 8'h05;
    localparam logic [7:0]  SUB_POL      = 8'h02;
    localparam logic [7:0]  SUB_EMG_LAST = 8'h03;
    localparam logic [7:0]  SUB_STP_LAST = 8'h05;

    // abort codes
    localparam logic [31:0] AB_NONE      = 32'h0000_0000;
    localparam logic [31:0] AB_LOCKED    = 32'h0800_0002;
    localparam logic [31:0] AB_RANGE     = 32'h0604_0030;
    localparam logic [31:0] AB_TOO_HIGH  = 32'h0609_0031;
    localparam logic [31:0] AB_TOO_LOW   = 32'h0609_0032;
    localparam logic [31:0] AB_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] AB_NO_SUB    = 32'h0609_0011;
    localparam logic [31:0] AB_NO_OBJ    = 32'h0602_0000;

    // values after reset and value limits
    localparam logic [15:0] ENTRY_COUNT  = 16'h0007;
    localparam logic [15:0] RST_OPTION   = 16'h0001;
    localparam logic [15:0] RST_HOLD     = 16'h000a;
    localparam logic [15:0] RST_STEP     = 16'h0064;
    localparam logic [15:0] RST_TMO      = 16'h01f4;
    localparam logic [15:0] RST_EMG_SEL  = 16'h0001;
    localparam logic [15:0] RST_EMG_POL  = 16'h0000;
    localparam logic [15:0] MAX_STEP     = 16'h1fff;
    localparam logic [15:0] STOP_RPM     = 16'h0005;

    // timing
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned TICK_MS      = 10;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

    // drive states
    typedef enum logic [2:0] {
        ST_SWON = 3'b001,
        ST_OPEN = 3'b010,
        ST_QSA  = 3'b100
    } dsei_state_type;

    // stop phases
    typedef enum logic [3:0] {
        PH_IDLE  = 4'b0001,
        PH_RAMP  = 4'b0010,
        PH_HOLD  = 4'b0100,
        PH_COAST = 4'b1000
    } dsei_phase_type;

    // controlword commands, one-cycle pulse when not none
    typedef enum logic [1:0] {
        CMD_NONE    = 2'h0,
        CMD_ENABLE  = 2'h1,
        CMD_DISABLE = 2'h2,
        CMD_QSTOP   = 2'h3
    } dsei_cmd_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [15:0] data;
    } dsei_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] abort;
        logic [15:0] data;
    } dsei_rsp_type;

endpackage : dsei_pkg

// >>> rtl/dsei_tick.sv
// Purpose: free running divider giving a one-cycle enable pulse
// Assumes: CYCLES of at least 2
// Notes:   pulse comes one cycle after the count reaches its last value, while it reads zero
`timescale 1ns/1ns
module dsei_tick
    import dsei_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // enable pulse
    output logic      tick
);
    localparam int unsigned W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_r;

    // wrap counter, pulse registered so it is glitch free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            tick  <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end

endmodule : dsei_tick

// >>> tb/dsei_master.sv
// Purpose: parameter and controlword master facing the stop block
// Assumes: requests change on the falling edge, answer one cycle later
// Notes:   save sequence not modelled, so parameters stay volatile
`timescale 1ns/1ns
module dsei_master
    import dsei_pkg::*;
(
    // clock
    input  wire logic         clk,
    // requests out
    output dsei_req_type      req,
    output dsei_cmd_type      cmd,
    // answers in
    input  wire dsei_rsp_type rsp
);
    // idle bus before the first access
    initial begin
        req = '0;
        cmd = CMD_NONE;
    end

    // one access; a missing ack shows as an impossible abort code
    task automatic sdo(input logic w, input logic [15:0] idx, input logic [7:0] sb,
                       input logic [15:0] d, output logic [31:0] ab, output logic [15:0] q);
        @(negedge clk);
        req = '{valid: 1'b1, write: w, index: idx, sub: sb, data: d};
        @(negedge clk);
        req = '0;
        ab  = (rsp.ack === 1'b1) ? rsp.abort : 32'hffff_ffff;
        q   = rsp.data;
    endtask : sdo

    // controlword command held for exactly one taking edge
    task automatic send(input dsei_cmd_type c);
        @(negedge clk);
        cmd = c;
        @(negedge clk);
        cmd = CMD_NONE;
    endtask : send
endmodule : dsei_master

// >>> tb/tb.sv
// Purpose: self-checking bench of the stop and emergency input block
// Assumes: short tick of 10 cycles so ramps finish quickly
// Notes:   alarm pulsed for one cycle to exercise its exit path
`timescale 1ns/1ns
module tb
    import dsei_pkg::*;
;
    logic clk, resetn, write_lock, emg_pin, alarm, torque_en, power_en, ramp_status, gp_input;
    logic [15:0] target_speed, actual_speed, speed_setpoint, q, brake_tmo;
    logic [31:0] ab;
    dsei_req_type req;
    dsei_rsp_type rsp;
    dsei_cmd_type cmd;
    dsei_state_type drv_state;
    int num_errors = 0;
    int n_tests = 0;

    dsei_ctrl #(.TICK_CYC(10)) i_dut (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
        .write_lock(write_lock), .cmd(cmd), .alarm(alarm), .emg_pin(emg_pin),
        .target_speed(target_speed), .actual_speed(actual_speed),
        .brake_timeout(brake_tmo), .drv_state(drv_state), .speed_setpoint(speed_setpoint),
        .torque_en(torque_en), .power_en(power_en), .ramp_status(ramp_status),
        .gp_input(gp_input));
    dsei_master i_m (.clk(clk), .req(req), .cmd(cmd), .rsp(rsp));

    // clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] idx, input logic [7:0] sb, input logic [15:0] e);
        i_m.sdo(1'b0, idx, sb, 16'h0000, ab, q);
        chk(ab, AB_NONE);
        chk({16'h0000, q}, {16'h0000, e});
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [7:0] sb, input logic [15:0] d,
                      input logic [31:0] e);
        i_m.sdo(1'b1, idx, sb, d, ab, q);
        chk(ab, e);
    endtask : wr

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // hang guard, well beyond the few hundred cycles the tests take
    initial begin
        #(100 * 20000);
        num_errors++;
        final_report();
    end

    initial begin
        resetn = 1'b0;
        write_lock = 1'b0;
        alarm = 1'b0;
        brake_tmo = 16'h0003;
        emg_pin = 1'b0;
        target_speed = 16'h0064;
        actual_speed = 16'h0000;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        // defaults and read-only entries
        rd(OBJ_STOP, SUB_COUNT, ENTRY_COUNT);
        rd(OBJ_STOP, SUB_OPTION, 16'h0001);
        rd(OBJ_EMG, SUB_OPTION, 16'h0001);
        rd(OBJ_EMG, SUB_POL, 16'h0000);
        rd(OBJ_EMG, SUB_STATUS, 16'h0000);
        // refused writes, value kept
        wr(OBJ_STOP, SUB_STATUS, 16'h0001, AB_READ_ONLY);
        rd(OBJ_STOP, SUB_STATUS, 16'h0000);
        wr(OBJ_STOP, 8'h06, 16'h0001, AB_NO_SUB);
        wr(OBJ_EMG, 8'h04, 16'h0001, AB_NO_SUB);
        wr(16'h3009, SUB_OPTION, 16'h0000, AB_NO_OBJ);
        wr(OBJ_STOP, SUB_STEP, 16'h01f4, AB_TOO_HIGH);
        wr(OBJ_STOP, SUB_TMO, 16'h0064, AB_TOO_LOW);
        wr(OBJ_STOP, SUB_OPTION, 16'h0002, AB_RANGE);
        write_lock = 1'b1;
        wr(OBJ_STOP, SUB_OPTION, 16'h0000, AB_LOCKED);
        write_lock = 1'b0;
        // run, change step live, ramp stop
        i_m.send(CMD_ENABLE);
        chk(drv_state, ST_OPEN);
        chk(speed_setpoint, target_speed);
        wr(OBJ_STOP, SUB_STEP, 16'h0032, AB_NONE);
        i_m.send(CMD_DISABLE);
        chk(drv_state, ST_SWON);
        chk(ramp_status, 1'b1);
        rd(OBJ_STOP, SUB_STATUS, 16'h0001);
        for (int i = 0; i < 40 && speed_setpoint === 16'h0064; i++) @(negedge clk);
        chk(speed_setpoint, 16'h0064 - 16'h0032);
        for (int i = 0; i < 400 && ramp_status === 1'b1; i++) @(negedge clk);
        chk({ramp_status, torque_en, power_en}, 3'b000);
        // emergency trips run, then blocks enable
        i_m.send(CMD_ENABLE);
        emg_pin = 1'b1;
        repeat (4) @(negedge clk);
        chk(drv_state, ST_SWON);
        rd(OBJ_EMG, SUB_STATUS, 16'h0001);
        i_m.send(CMD_ENABLE);
        chk(drv_state, ST_SWON);
        emg_pin = 1'b0;
        repeat (200) @(negedge clk);
        // quick stop and its exit
        i_m.send(CMD_ENABLE);
        i_m.send(CMD_QSTOP);
        chk({drv_state, torque_en}, {ST_QSA, 1'b0});
        i_m.send(CMD_ENABLE);
        chk(drv_state, ST_OPEN);
        i_m.send(CMD_QSTOP);
        i_m.send(CMD_DISABLE);
        chk({drv_state, power_en}, {ST_SWON, 1'b0});
        // coast stop: below 5 rpm, then brake timeout
        wr(OBJ_STOP, SUB_OPTION, 16'h0000, AB_NONE);
        actual_speed = 16'h0064;
        i_m.send(CMD_ENABLE);
        i_m.send(CMD_DISABLE);
        repeat (5) @(negedge clk);
        chk({torque_en, ramp_status}, 2'b10);
        actual_speed = 16'h0003;
        repeat (2) @(negedge clk);
        chk(torque_en, 1'b0);
        actual_speed = 16'h0064;
        i_m.send(CMD_ENABLE);
        i_m.send(CMD_DISABLE);
        repeat (45) @(negedge clk);
        chk(torque_en, 1'b0);
        // alarm exit, ramp cut short by a two tick timeout
        wr(OBJ_STOP, SUB_OPTION, 16'h0001, AB_NONE);
        wr(OBJ_STOP, SUB_STEP, 16'h0001, AB_NONE);
        wr(OBJ_STOP, SUB_TMO, 16'h0002, AB_NONE);
        i_m.send(CMD_ENABLE);
        alarm = 1'b1;
        @(negedge clk);
        alarm = 1'b0;
        chk({drv_state, ramp_status}, {ST_SWON, 1'b1});
        repeat (40) @(negedge clk);
        chk({ramp_status, torque_en, speed_setpoint}, {2'b00, 16'h0000});
        // polarity and general purpose use of the pin
        wr(OBJ_EMG, SUB_POL, 16'h0001, AB_NONE);
        repeat (2) @(negedge clk);
        rd(OBJ_EMG, SUB_STATUS, 16'h0001);
        wr(OBJ_EMG, SUB_OPTION, 16'h0000, AB_NONE);
        emg_pin = 1'b1;
        repeat (2) @(negedge clk);
        chk(gp_input, 1'b1);
        // a save would be allowed here: out of run and quick-stop
        chk(drv_state, ST_SWON);
        final_report();
    end
endmodule : tb
